// [hdl/rppl_regs.svh]
// Slot indices, protocol numbers and preset byte values of the loader.
// Assumes inclusion by bare name from the loader and its table.
`ifndef RPPL_REGS_SVH
`define RPPL_REGS_SVH

// Slot positions in the fixed write order
`define RP_SLOT_FIRST 5'h00
`define RP_SLOT_STEP 5'h01
`define RP_SLOT_LAST 5'h17
`define RP_SLOT_TX_CODING 5'h00
`define RP_SLOT_RESERVED 5'h01
`define RP_SLOT_DATA_CTRL 5'h02
`define RP_SLOT_DATA_MOD 5'h03
`define RP_SLOT_SYM_FREQ 5'h04
`define RP_SLOT_SYM0_LOW 5'h06
`define RP_SLOT_SYM1_LOW 5'h08
`define RP_SLOT_PAIR_A_LEN 5'h0B
`define RP_SLOT_PAIR_A_MOD 5'h0E
`define RP_SLOT_PAIR_B_MOD 5'h0F
`define RP_SLOT_RX_CODING 5'h10
`define RP_SLOT_SYNC_LOW 5'h13
`define RP_SLOT_SYNC_MODE 5'h14
`define RP_SLOT_RX_MODE 5'h15
`define RP_SLOT_CORRELATOR 5'h16
`define RP_SLOT_CALIBRATION 5'h17

// Protocol numbers
`define RP_PROTO_A106 8'h00
`define RP_PROTO_A212 8'h01
`define RP_PROTO_A424 8'h02
`define RP_PROTO_A848 8'h03
`define RP_PROTO_B106 8'h04

// Preset values
`define RP_V_ZERO 8'h00
`define RP_V_A_TX_CODING 8'h20
`define RP_V_A_DATA_MOD 8'h50
`define RP_V_A_PAIR_B_MOD 8'h50
`define RP_V_A106_DATA_CTRL 8'h04
`define RP_V_A212_DATA_CTRL 8'h05
`define RP_V_A424_DATA_CTRL 8'h06
`define RP_V_A848_DATA_CTRL 8'h07
`define RP_V_A106_SYM_FREQ 8'h40
`define RP_V_A212_SYM_FREQ 8'h50
`define RP_V_A424_SYM_FREQ 8'h60
`define RP_V_A848_SYM_FREQ 8'h70
`define RP_V_A106_RX_CODING 8'h02
`define RP_V_AHI_RX_CODING 8'h22
`define RP_V_A106_SYNC_LOW 8'h01
`define RP_V_A106_RX_MODE 8'h08
`define RP_V_AHI_RX_MODE 8'h0D
`define RP_V_CORRELATOR 8'h80
`define RP_V_CALIBRATION 8'hB2
`define RP_V_B_TX_CODING 8'h09
`define RP_V_B_DATA_CTRL 8'h04
`define RP_V_B_DATA_MOD 8'h08
`define RP_V_B_SYM_FREQ 8'h04
`define RP_V_B_SYM0_LOW 8'h03
`define RP_V_B_SYM1_LOW 8'h01
`define RP_V_B_PAIR_A_LEN 8'hAB
`define RP_V_B_PAIR_A_MOD 8'h08
`define RP_V_B_RX_CODING 8'h04
`define RP_V_B_SYNC_MODE 8'h02
`define RP_V_B_RX_MODE_PLAIN 8'h1D
`define RP_V_B_RX_MODE_STORED 8'h0D

// Reset values
`define RP_RST_BYTE 8'h00
`define RP_RST_SLOT 5'h00
`define RP_RST_BIT 1'b0

`endif

// [hdl/rppl_pkg.sv]
// Types shared by the preset loader and its table.
// Assumes the constants header is compiled alongside.
package rppl_pkg;
   typedef logic [7:0] rppl_byte_t;
   typedef logic [4:0] rppl_slot_t;
   typedef enum logic [1:0] {
      RPPL_IDLE,
      RPPL_WRITE,
      RPPL_DONE
   } rppl_state_e;
endpackage

// [hdl/rppl_lookup_if.sv]
// Lookup channel between the loader sequencer and the preset table.
// Assumes both ends share one clock; the table is combinational.
`timescale 1ns/10ps
interface rppl_lookup_if;
   import rppl_pkg::*;
   rppl_byte_t protocol;
   rppl_slot_t slot;
   logic stored_antenna;
   rppl_byte_t value;
   logic supported;
   modport table_end (
      input protocol, slot, stored_antenna,
      output value, supported
   );
   modport user_end (
      output protocol, slot, stored_antenna,
      input value, supported
   );
endinterface

// [hdl/rppl_preset_table.sv]
// Preset byte for a given protocol number and slot.
// Assumes the lookup interface; purely combinational.
`timescale 1ns/10ps
`include "rppl_regs.svh"
module rppl_preset_table
   import rppl_pkg::*;
(
   rppl_lookup_if.table_end lk
);
   rppl_byte_t a_ctrl;
   rppl_byte_t a_freq;
   rppl_byte_t a_rx_coding;
   rppl_byte_t a_sync_low;
   rppl_byte_t a_rx_mode;

   // Type A rates differ only in a few bytes
   always_comb begin
      a_ctrl = `RP_V_A106_DATA_CTRL;
      a_freq = `RP_V_A106_SYM_FREQ;
      a_rx_coding = `RP_V_AHI_RX_CODING;
      a_sync_low = `RP_V_ZERO;
      a_rx_mode = `RP_V_AHI_RX_MODE;
      case (lk.protocol)
         `RP_PROTO_A106: begin
            a_rx_coding = `RP_V_A106_RX_CODING;
            a_sync_low = `RP_V_A106_SYNC_LOW;
            a_rx_mode = `RP_V_A106_RX_MODE;
         end
         `RP_PROTO_A212: begin
            a_ctrl = `RP_V_A212_DATA_CTRL;
            a_freq = `RP_V_A212_SYM_FREQ;
         end
         `RP_PROTO_A424: begin
            a_ctrl = `RP_V_A424_DATA_CTRL;
            a_freq = `RP_V_A424_SYM_FREQ;
         end
         `RP_PROTO_A848: begin
            a_ctrl = `RP_V_A848_DATA_CTRL;
            a_freq = `RP_V_A848_SYM_FREQ;
         end
         default: begin
         end
      endcase
   end

   // Slots not named below, the reserved one among them, read zero
   always_comb begin
      lk.value = `RP_V_ZERO;
      lk.supported = 1'b1;
      case (lk.protocol)
         `RP_PROTO_A106, `RP_PROTO_A212, `RP_PROTO_A424,
         `RP_PROTO_A848: begin
            case (lk.slot)
               `RP_SLOT_TX_CODING: lk.value = `RP_V_A_TX_CODING;
               `RP_SLOT_DATA_CTRL: lk.value = a_ctrl;
               `RP_SLOT_DATA_MOD: lk.value = `RP_V_A_DATA_MOD;
               `RP_SLOT_SYM_FREQ: lk.value = a_freq;
               `RP_SLOT_PAIR_B_MOD: lk.value = `RP_V_A_PAIR_B_MOD;
               `RP_SLOT_RX_CODING: lk.value = a_rx_coding;
               `RP_SLOT_SYNC_LOW: lk.value = a_sync_low;
               `RP_SLOT_RX_MODE: lk.value = a_rx_mode;
               `RP_SLOT_CORRELATOR: lk.value = `RP_V_CORRELATOR;
               `RP_SLOT_CALIBRATION: lk.value = `RP_V_CALIBRATION;
               default: lk.value = `RP_V_ZERO;
            endcase
         end
         `RP_PROTO_B106: begin
            case (lk.slot)
               `RP_SLOT_TX_CODING: lk.value = `RP_V_B_TX_CODING;
               `RP_SLOT_DATA_CTRL: lk.value = `RP_V_B_DATA_CTRL;
               `RP_SLOT_DATA_MOD: lk.value = `RP_V_B_DATA_MOD;
               `RP_SLOT_SYM_FREQ: lk.value = `RP_V_B_SYM_FREQ;
               `RP_SLOT_SYM0_LOW: lk.value = `RP_V_B_SYM0_LOW;
               `RP_SLOT_SYM1_LOW: lk.value = `RP_V_B_SYM1_LOW;
               `RP_SLOT_PAIR_A_LEN: lk.value = `RP_V_B_PAIR_A_LEN;
               `RP_SLOT_PAIR_A_MOD: lk.value = `RP_V_B_PAIR_A_MOD;
               `RP_SLOT_RX_CODING: lk.value = `RP_V_B_RX_CODING;
               `RP_SLOT_SYNC_MODE: lk.value = `RP_V_B_SYNC_MODE;
               `RP_SLOT_RX_MODE: begin
                  lk.value = lk.stored_antenna ?
                     `RP_V_B_RX_MODE_STORED : `RP_V_B_RX_MODE_PLAIN;
               end
               `RP_SLOT_CORRELATOR: lk.value = `RP_V_CORRELATOR;
               `RP_SLOT_CALIBRATION: lk.value = `RP_V_CALIBRATION;
               default: lk.value = `RP_V_ZERO;
            endcase
         end
         default: lk.supported = 1'b0;
      endcase
   end
endmodule

// [hdl/rppl_loader.sv]
// Protocol preset loader: on a load command, writes the preset table
// of the requested protocol into the radio configuration registers.
// Assumes a configuration register file that accepts one byte a cycle
// on the write port and holds the antenna settings elsewhere.
`timescale 1ns/10ps
`include "rppl_regs.svh"
module rppl_loader
   import rppl_pkg::*;
#(
   parameter int SLOT_W = 5,
   parameter int DATA_W = 8,
   parameter int SLOT_COUNT = 24
)
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // Load command
   input wire logic cmd_valid_in,
   input wire logic [DATA_W-1:0] protocol_in,
   output logic cmd_ready_out,
   output logic cmd_done_out,
   output logic cmd_error_out,
   // Product variant strap
   input wire logic stored_antenna_cfg_in,
   // Configuration register write port
   output logic cfg_wr_out,
   output logic [SLOT_W-1:0] cfg_index_out,
   output logic [DATA_W-1:0] cfg_data_out,
   // Status
   output logic busy_out,
   output logic preset_valid_out,
   output logic [DATA_W-1:0] active_protocol_out,
   output logic stored_antenna_out,
   // Readback of the last written preset
   input wire logic [SLOT_W-1:0] rd_index_in,
   output logic [DATA_W-1:0] rd_data_out
);
   rppl_lookup_if lk ();

   rppl_state_e state_reg;
   rppl_state_e state_next;
   rppl_slot_t slot_reg;
   rppl_byte_t protocol_reg;
   logic strap_taken_reg;
   logic stored_antenna_reg;
   logic wr_reg;
   rppl_slot_t index_reg;
   rppl_byte_t data_reg;
   logic done_reg;
   logic error_reg;
   logic valid_reg;
   rppl_byte_t rd_reg;
   rppl_byte_t shadow [SLOT_COUNT];
   logic take_cmd;
   logic last_slot;

   rppl_preset_table u_table (
      .lk (lk.table_end)
   );

   // Protocol number is looked up while idle to vet a new command
   assign lk.protocol = (state_reg == RPPL_IDLE) ? protocol_in
                                                 : protocol_reg;
   assign lk.slot = slot_reg;
   assign lk.stored_antenna = stored_antenna_reg;

   assign take_cmd = (state_reg == RPPL_IDLE) && cmd_valid_in;
   assign last_slot = (slot_reg == `RP_SLOT_LAST);

   // Variant strap is caught once after reset release, so a strap pin
   // that moves later cannot change a preset halfway through a load
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         strap_taken_reg <= `RP_RST_BIT;
         stored_antenna_reg <= `RP_RST_BIT;
      end else if (!strap_taken_reg) begin
         strap_taken_reg <= 1'b1;
         stored_antenna_reg <= stored_antenna_cfg_in;
      end
   end

   // Sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         RPPL_IDLE: begin
            if (take_cmd && lk.supported) begin
               state_next = RPPL_WRITE;
            end
         end
         RPPL_WRITE: begin
            if (last_slot) begin
               state_next = RPPL_DONE;
            end
         end
         RPPL_DONE: begin
            state_next = RPPL_IDLE;
         end
      endcase
   end


   // State register; a refused number never leaves idle
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         state_reg <= RPPL_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Slot counter walks the table in its fixed order
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         slot_reg <= `RP_RST_SLOT;
      end else if (state_reg == RPPL_WRITE) begin
         slot_reg <= last_slot ? `RP_SLOT_FIRST
                               : slot_reg + `RP_SLOT_STEP;
      end else begin
         slot_reg <= `RP_SLOT_FIRST;
      end
   end

   // Requested protocol held for the whole load
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         protocol_reg <= `RP_RST_BYTE;
      end else if (take_cmd && lk.supported) begin
         protocol_reg <= protocol_in;
      end
   end

   // Write port: slot indices cover only the preset, never antenna
   // registers, which the variant keeps in its own store
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         wr_reg <= `RP_RST_BIT;
         index_reg <= `RP_RST_SLOT;
         data_reg <= `RP_RST_BYTE;
      end else if (state_reg == RPPL_WRITE) begin
         wr_reg <= 1'b1;
         index_reg <= slot_reg;
         data_reg <= lk.value;
      end else begin
         wr_reg <= 1'b0;
      end
   end

   // Completion and refusal pulses
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         done_reg <= `RP_RST_BIT;
      end else begin
         done_reg <= (state_reg == RPPL_DONE);
      end
   end


   // The number is vetted in the cycle it is taken, so an unknown
   // protocol writes nothing and the next request may follow at once
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         error_reg <= `RP_RST_BIT;
      end else begin
         error_reg <= take_cmd && !lk.supported;
      end
   end

   // Preset valid falls when a new load starts, rises at completion
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         valid_reg <= `RP_RST_BIT;
      end else if (take_cmd && lk.supported) begin
         valid_reg <= 1'b0;
      end else if (state_reg == RPPL_DONE) begin
         valid_reg <= 1'b1;
      end
   end


   // Copy of every byte driven on the write port
   // Not reset: a slot reads back a defined value only after a load
   always_ff @(posedge sys_clk_in) begin
      if (wr_reg) begin
         shadow[index_reg] <= data_reg;
      end
   end


   // Readback lags its index by one cycle; indices past the table read 0
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         rd_reg <= `RP_RST_BYTE;
      end else if (rd_index_in <= `RP_SLOT_LAST) begin
         rd_reg <= shadow[rd_index_in];
      end else begin
         rd_reg <= `RP_RST_BYTE;
      end
   end


   // Ready and busy decode the state; all other outputs, done and error among them, are flip-flops
   assign cmd_ready_out = (state_reg == RPPL_IDLE);
   assign cmd_done_out = done_reg;
   assign cmd_error_out = error_reg;
   assign cfg_wr_out = wr_reg;
   assign cfg_index_out = index_reg;
   assign cfg_data_out = data_reg;
   assign busy_out = (state_reg != RPPL_IDLE);
   assign preset_valid_out = valid_reg;
   assign active_protocol_out = protocol_reg;
   assign stored_antenna_out = stored_antenna_reg;
   assign rd_data_out = rd_reg;
endmodule

// [verif/rppl_loader_checker.sv]
// Assertions on the preset loader's top ports.
// Assumes binding to rppl_loader; one clock domain.
`timescale 1ns/10ps
module rppl_loader_checker #(
   parameter int SLOT_W = 5,
   parameter int DATA_W = 8,
   parameter int SLOT_COUNT = 24
)(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // Command and status
   input wire logic cmd_valid_in,
   input wire logic [DATA_W-1:0] protocol_in,
   input wire logic cmd_ready_out,
   input wire logic cmd_done_out,
   input wire logic cmd_error_out,
   input wire logic busy_out,
   input wire logic preset_valid_out,
   input wire logic [DATA_W-1:0] active_protocol_out,
   input wire logic stored_antenna_out,
   // Write port
   input wire logic cfg_wr_out,
   input wire logic [SLOT_W-1:0] cfg_index_out,
   input wire logic [DATA_W-1:0] cfg_data_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_take;
      cmd_valid_in && cmd_ready_out;
   endsequence
   // Twenty-four consecutive write cycles
   sequence s_burst;
      cfg_wr_out[*8] ##1 cfg_wr_out[*8] ##1 cfg_wr_out[*8];
   endsequence
   good_load_done_a: assert property (s_take ##0 protocol_in <= 8'h04
      |-> ##26 cmd_done_out) else $error("done not 26 cycles after take");
   bad_proto_a: assert property (s_take ##0 protocol_in > 8'h04
      |=> cmd_error_out && !cfg_wr_out && cmd_ready_out)
      else $error("unsupported protocol not refused");
   burst_len_a: assert property ($rose(cfg_wr_out)
      |-> s_burst ##1 !cfg_wr_out) else $error("burst is not 24 writes");
   first_slot_a: assert property ($rose(cfg_wr_out)
      |-> cfg_index_out == 5'h00) else $error("burst not at slot 0");
   slot_step_a: assert property (cfg_wr_out && $past(cfg_wr_out)
      |-> cfg_index_out == $past(cfg_index_out) + 5'h01)
      else $error("slots not ascending");
   slot_range_a: assert property (cfg_wr_out
      |-> cfg_index_out <= 5'h17) else $error("write outside preset slots");
   reserved_zero_a: assert property (cfg_wr_out && cfg_index_out == 5'h01
      |-> cfg_data_out == 8'h00) else $error("reserved slot not zero");
   calib_value_a: assert property (cfg_wr_out && cfg_index_out == 5'h17
      |-> cfg_data_out == 8'hB2) else $error("calibration byte wrong");
   rx_mode_b_a: assert property (cfg_wr_out && cfg_index_out == 5'h15
      && active_protocol_out == 8'h04
      |-> cfg_data_out == (stored_antenna_out ? 8'h0D : 8'h1D))
      else $error("type B receive mode wrong");
   done_idle_a: assert property (cmd_done_out
      |-> cmd_ready_out && !busy_out && preset_valid_out && !cfg_wr_out)
      else $error("done without idle state");
endmodule
bind rppl_loader rppl_loader_checker #(.SLOT_W(SLOT_W), .DATA_W(DATA_W),
   .SLOT_COUNT(SLOT_COUNT)) chk (.sys_clk_in(sys_clk_in),
   .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
   .protocol_in(protocol_in), .cmd_ready_out(cmd_ready_out),
   .cmd_done_out(cmd_done_out), .cmd_error_out(cmd_error_out),
   .busy_out(busy_out), .preset_valid_out(preset_valid_out),
   .active_protocol_out(active_protocol_out),
   .stored_antenna_out(stored_antenna_out), .cfg_wr_out(cfg_wr_out),
   .cfg_index_out(cfg_index_out), .cfg_data_out(cfg_data_out));

// [verif/rppl_cfg_model.sv]
// Model of the configuration register file behind the loader.
// Assumes one byte a cycle on the write port, no back-pressure.
`timescale 1ns/10ps
module rppl_cfg_model (
   // Clock
   input wire logic clk_in,
   // Write port
   input wire logic wr_in,
   input wire logic [4:0] index_in,
   input wire logic [7:0] data_in,
   // Contents and counters
   output logic [7:0] mem_out [24],
   output logic [15:0] wr_count_out,
   output logic fault_out
);
   logic [4:0] last_reg;
   initial begin
      wr_count_out = 16'h0000;
      fault_out = 1'b0;
      last_reg = 5'h17;
   end
   always @(posedge clk_in) begin
      if (wr_in) begin
         wr_count_out <= wr_count_out + 16'h0001;
         if (index_in > 5'h17) fault_out <= 1'b1;
         else mem_out[index_in] <= data_in;
         // Each burst restarts at slot 0 after slot 23
         if (index_in != ((last_reg == 5'h17) ? 5'h00 : last_reg + 5'h01))
            fault_out <= 1'b1;
         last_reg <= index_in;
      end
   end
endmodule

// [verif/rppl_loader_tb.sv]
// Self-checking bench for the preset loader.
// Assumes the checker bind and the register file model.
`timescale 1ns/10ps
module rppl_loader_tb;
   import rppl_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic cmd_valid_in = 1'b0;
   logic [7:0] protocol_in = 8'h00;
   logic stored_antenna_cfg_in = 1'b0;
   logic [4:0] rd_index_in = 5'h00;
   logic cmd_ready_out, cmd_done_out, cmd_error_out, cfg_wr_out;
   logic busy_out, preset_valid_out, stored_antenna_out, fault, err;
   logic [4:0] cfg_index_out;
   logic [7:0] cfg_data_out, active_protocol_out, rd_data_out;
   logic [7:0] mem [24];
   logic [15:0] wr_count, cnt0;
   int miscompares = 0;
   int check_count = 0;
   int lat;
   always #4 sys_clk_in = ~sys_clk_in;
   rppl_loader dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .cmd_valid_in(cmd_valid_in), .protocol_in(protocol_in),
      .cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out),
      .cmd_error_out(cmd_error_out),
      .stored_antenna_cfg_in(stored_antenna_cfg_in),
      .cfg_wr_out(cfg_wr_out), .cfg_index_out(cfg_index_out),
      .cfg_data_out(cfg_data_out), .busy_out(busy_out),
      .preset_valid_out(preset_valid_out),
      .active_protocol_out(active_protocol_out),
      .stored_antenna_out(stored_antenna_out),
      .rd_index_in(rd_index_in), .rd_data_out(rd_data_out));
   rppl_cfg_model regs (.clk_in(sys_clk_in), .wr_in(cfg_wr_out),
      .index_in(cfg_index_out), .data_in(cfg_data_out), .mem_out(mem),
      .wr_count_out(wr_count), .fault_out(fault));
   task chk(input logic [15:0] got, input logic [15:0] exp, input string w);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function logic [7:0] exp_val(logic [7:0] p, int s, logic st);
      logic [7:0] v [24];
      v = '{default: 8'h00};
      if (p == 8'h04) begin
         v[0] = 8'h09; v[2] = 8'h04; v[3] = 8'h08; v[4] = 8'h04;
         v[6] = 8'h03; v[8] = 8'h01; v[11] = 8'hAB; v[14] = 8'h08;
         v[16] = 8'h04; v[20] = 8'h02; v[21] = st ? 8'h0D : 8'h1D;
      end else begin
         v[0] = 8'h20; v[2] = 8'h04 + p; v[3] = 8'h50;
         v[4] = 8'h40 + p * 8'h10; v[15] = 8'h50;
         v[16] = (p == 8'h00) ? 8'h02 : 8'h22;
         v[19] = (p == 8'h00) ? 8'h01 : 8'h00;
         v[21] = (p == 8'h00) ? 8'h08 : 8'h0D;
      end
      v[22] = 8'h80;
      v[23] = 8'hB2;
      return v[s];
   endfunction
   task reset_dut(input logic strap);
      stored_antenna_cfg_in = strap;
      rst_b_in = 1'b0;
      repeat (5) @(negedge sys_clk_in);
      rst_b_in = 1'b1;
      repeat (2) @(negedge sys_clk_in);
   endtask
   // Returns at the falling edge of the done or error cycle
   task load(input logic [7:0] p);
      cmd_valid_in = 1'b1;
      protocol_in = p;
      cnt0 = wr_count;
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      cmd_valid_in = 1'b0;
      lat = 1;
      while (cmd_done_out !== 1'b1 && cmd_error_out !== 1'b1 && lat < 40) begin
         @(negedge sys_clk_in);
         lat++;
      end
      err = cmd_error_out;
   endtask
   task check_preset(input logic [7:0] p, input logic st);
      chk(16'(lat), 16'h001A, "latency");
      chk(err, 1'b0, "error");
      chk(wr_count - cnt0, 16'h0018, "writes");
      chk(active_protocol_out, p, "protocol");
      chk(preset_valid_out, 1'b1, "valid");
      for (int s = 0; s < 24; s++) begin
         rd_index_in = 5'(s);
         @(negedge sys_clk_in);
         chk(mem[s], exp_val(p, s, st), "slot");
         chk(rd_data_out, exp_val(p, s, st), "readback");
      end
   endtask
   initial begin
      reset_dut(1'b0);
      chk(stored_antenna_out, 1'b0, "strap");
      for (int p = 0; p < 5; p++) begin
         load(8'(p));
         check_preset(8'(p), 1'b0);
         $display("test preset %0d done", p);
      end
      load(8'h01);
      load(8'h02);
      check_preset(8'h02, 1'b0);
      $display("test back to back done");
      for (int i = 0; i < 8; i += 7) begin
         load((i == 0) ? 8'h05 : 8'hFF);
         chk(16'(lat), 16'h0001, "error latency");
         chk(wr_count - cnt0, 16'h0000, "refused writes");
         chk(cmd_ready_out, 1'b1, "ready");
         @(negedge sys_clk_in);
      end
      $display("test refusal done");
      reset_dut(1'b1);
      chk(stored_antenna_out, 1'b1, "strap");
      load(8'h04);
      check_preset(8'h04, 1'b1);
      chk(fault, 1'b0, "order");
      $display("test stored variant done");
      end_of_test;
   end
   initial begin
      repeat (4000) @(posedge sys_clk_in);
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test;
   end
endmodule
